// >>> include/bbo_params.svh
// constants for the byte and bit operation execute unit
// assumes an 8-bit register address on the avalon-mm slave, word aligned
`ifndef BBO_PARAMS_SVH
`define BBO_PARAMS_SVH

// register byte offsets
`define BBO_OFF_INSTR     8'h00
`define BBO_OFF_ACC       8'h04
`define BBO_OFF_FLAGS     8'h08
`define BBO_OFF_PC        8'h0c
`define BBO_OFF_CTRL      8'h10
`define BBO_OFF_PIN_DIR   8'h14
`define BBO_OFF_STAT      8'h18
`define BBO_OFF_LATCH     8'h1c
`define BBO_OFF_ICOUNT    8'h20
`define BBO_FILE_WIN_BIT  7

// field positions
`define BBO_CTRL_PSA_BIT  0
`define BBO_STAT_BUSY_BIT 0
`define BBO_STAT_SKIP_BIT 1
`define BBO_STAT_PCLD_BIT 2

// reset values
`define BBO_RST_ACC       8'h00
`define BBO_RST_FLAGS     3'h0
`define BBO_RST_PC        9'h000
`define BBO_RST_CTRL      1'h0
`define BBO_RST_DIR       8'hff
`define BBO_RST_LATCH     8'h00
`define BBO_RST_IR        12'h000

// special file addresses
`define BBO_FILE_COUNTER  5'h01
`define BBO_FILE_PCL      5'h02
`define BBO_FILE_IO       5'h06

// opcode patterns
`define BBO_OPC_SUM       6'h07
`define BBO_OPC_AND_REG   6'h05
`define BBO_OPC_ZERO_ACC  12'h040
`define BBO_OPC_AND_IMM   4'he
`define BBO_OPC_BITOP     2'h1
`define BBO_OPC_JUMP      3'h5
`define BBO_OPC_PIN_DIR   12'h006
`define BBO_BIT_CLEAR     2'h0
`define BBO_BIT_SET       2'h1
`define BBO_BIT_SKIP_LOW  2'h2

// timing: one instruction cycle is four oscillator periods of clk
`define BBO_OSC_PER_CYCLE 4
`define BBO_EXEC_PHASE    2'h1

`endif

// >>> include/bbo_pkg.sv
// types shared by the execute unit and its decoder
// assumes bbo_params.svh is on the include path
package bbo_pkg;

	typedef enum logic [1:0] {
		CORE_IDLE  = 2'b00,
		CORE_EXEC  = 2'b01,
		CORE_FLUSH = 2'b10
	} bbo_core_t;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_DATA = 2'b01,
		BUS_ACK  = 2'b10
	} bbo_bus_t;

	typedef struct packed {
		logic ripple_out;
		logic nibble_carry;
		logic result_null;
	} bbo_flags_t;

	typedef struct packed {
		logic [7:0] result;
		bbo_flags_t flags;
		bbo_flags_t upd;
		logic       wr_acc;
		logic       wr_file;
		logic       skip;
		logic       pin_dir;
		logic       jump;
	} bbo_alu_out_t;

endpackage

// >>> verilog/bbo_fmem.sv
// file register memory: one write port, one read port with registered data
// assumes a single clock; read data valid the cycle after the address
`timescale 1ns/1ps
module bbo_fmem #(
	parameter int DEPTH = 32,
	parameter int WIDTH = 8,
	parameter int AW    = 5
) (
	// clock
	input  wire logic             clk,
	// write port
	input  wire logic             we,
	input  wire logic [AW-1:0]    waddr,
	input  wire logic [WIDTH-1:0] wdata,
	// read port
	input  wire logic [AW-1:0]    raddr,
	output logic      [WIDTH-1:0] rdata_q
);
	logic [WIDTH-1:0] mem [DEPTH];

	// no reset: contents are undefined at power up, as file registers are
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata_q <= mem[raddr];
	end
endmodule // bbo_fmem

// >>> verilog/bbo_alu.sv
// decoder and arithmetic for the byte and bit operations
// assumes the operand already reflects pin levels for the io group
`timescale 1ns/1ps
`include "bbo_params.svh"
module bbo_alu (
	// operands
	input  wire logic [11:0]          instr,
	input  wire logic [7:0]           acc,
	input  wire logic [7:0]           operand,
	// result
	output bbo_pkg::bbo_alu_out_t     res
);
	import bbo_pkg::*;

	logic [8:0] sum;
	logic [4:0] nib;
	logic [7:0] bmask;
	logic       tbit;

	assign sum   = {1'b0, acc} + {1'b0, operand};
	assign nib   = {1'b0, acc[3:0]} + {1'b0, operand[3:0]};
	assign bmask = 8'h01 << instr[7:5];
	assign tbit  = |(operand & bmask);

	always_comb begin
		res = '0;
		if (instr[11:6] == `BBO_OPC_SUM) begin
			res.result             = sum[7:0];
			res.flags.ripple_out   = sum[8];
			res.flags.nibble_carry = nib[4];
			res.flags.result_null  = (sum[7:0] == 8'h00);
			res.upd                = 3'h7;
			res.wr_acc             = ~instr[5];
			res.wr_file            = instr[5];
		end else if (instr[11:6] == `BBO_OPC_AND_REG) begin
			res.result             = acc & operand;
			res.flags.result_null  = ((acc & operand) == 8'h00);
			res.upd.result_null    = 1'b1;
			res.wr_acc             = ~instr[5];
			res.wr_file            = instr[5];
		end else if (instr[11:8] == `BBO_OPC_AND_IMM) begin
			res.result             = acc & instr[7:0];
			res.flags.result_null  = ((acc & instr[7:0]) == 8'h00);
			res.upd.result_null    = 1'b1;
			res.wr_acc             = 1'b1;
		end else if (instr == `BBO_OPC_ZERO_ACC) begin
			res.result             = 8'h00;
			res.flags.result_null  = 1'b1;
			res.upd.result_null    = 1'b1;
			res.wr_acc             = 1'b1;
		end else if (instr == `BBO_OPC_PIN_DIR) begin
			res.pin_dir            = 1'b1;
		end else if (instr[11:9] == `BBO_OPC_JUMP) begin
			res.jump               = 1'b1;
		end else if (instr[11:10] == `BBO_OPC_BITOP) begin
			case (instr[9:8])
				`BBO_BIT_CLEAR: begin
					res.result  = operand & ~bmask;
					res.wr_file = 1'b1;
				end
				`BBO_BIT_SET: begin
					res.result  = operand | bmask;
					res.wr_file = 1'b1;
				end
				`BBO_BIT_SKIP_LOW: begin
					res.skip    = ~tbit;
				end
				default: begin
					res.skip    = tbit;
				end
			endcase
		end
	end
endmodule // bbo_alu

// >>> verilog/bbo_exec.sv
// byte and bit operation execute unit with avalon-mm register access
// assumes clk is the oscillator; software issues one instruction at a time
`timescale 1ns/1ps
`include "bbo_params.svh"
module bbo_exec (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// avalon-mm slave
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// io pin group
	input  wire logic [7:0]  pin_in,
	output logic      [7:0]  pin_out,
	output logic      [7:0]  pin_oe_n,
	// counter side effect
	output logic             prescaler_clear
);
	import bbo_pkg::*;

	localparam logic [1:0] LAST_PHASE = 2'(`BBO_OSC_PER_CYCLE - 1);

	// bus group
	bbo_bus_t    bus_q, bus_d;
	logic        wait_q, wait_d;
	logic [31:0] rdata_q, rdata_d;
	logic        bus_wr;
	logic [7:0]  bus_off;
	logic        bus_file;
	logic [4:0]  bus_fidx;

	// core group
	bbo_core_t   core_q, core_d;
	logic [1:0]  phase_q, phase_d;
	logic [11:0] ir_q, ir_d;
	logic [7:0]  acc_q, acc_d;
	bbo_flags_t  flags_q, flags_d;
	logic [8:0]  pc_q, pc_d;
	logic        psa_q, psa_d;
	logic [7:0]  dir_q, dir_d;
	logic [7:0]  latch_q, latch_d;
	logic        skip_q, skip_d;
	logic        pcload_q, pcload_d;
	logic        psc_clr_q, psc_clr_d;
	logic [15:0] icount_q, icount_d;

	// datapath
	logic [4:0]   fsel;
	logic [7:0]   operand;
	bbo_alu_out_t alu;
	logic         mem_we;
	logic [4:0]   mem_wa;
	logic [7:0]   mem_wd;
	logic [4:0]   mem_ra;
	logic [7:0]   mem_rdata;

	assign bus_off  = {avs_address[7:2], 2'b00};
	assign bus_file = avs_address[`BBO_FILE_WIN_BIT];
	assign bus_fidx = avs_address[6:2];
	assign fsel     = ir_q[4:0];

	// io group reads the pins, not the latch, so read-modify-write sees pin levels
	assign operand = (fsel == `BBO_FILE_IO)  ? pin_in :
	                 (fsel == `BBO_FILE_PCL) ? pc_q[7:0] :
	                 mem_rdata;

	bbo_alu u_alu (
		.instr   (ir_q),
		.acc     (acc_q),
		.operand (operand),
		.res     (alu)
	);

	bbo_fmem #(
		.DEPTH (32),
		.WIDTH (8),
		.AW    (5)
	) u_fmem (
		.clk     (clk),
		.we      (mem_we),
		.waddr   (mem_wa),
		.wdata   (mem_wd),
		.raddr   (mem_ra),
		.rdata_q (mem_rdata)
	);

	// bus: request taken only while the core is idle, so no write races execution
	always_comb begin
		bus_d   = bus_q;
		wait_d  = 1'b1;
		rdata_d = rdata_q;
		bus_wr  = 1'b0;
		case (bus_q)
			BUS_IDLE: begin
				if ((avs_read || avs_write) && core_q == CORE_IDLE) begin
					bus_d = BUS_DATA;
				end
			end
			BUS_DATA: begin
				bus_wr = avs_write;
				wait_d = 1'b0;
				bus_d  = BUS_ACK;
				if (avs_read) begin
					rdata_d = 32'h0000_0000;
					if (bus_file) begin
						rdata_d[7:0] = mem_rdata;
					end else begin
						case (bus_off)
							`BBO_OFF_INSTR:   rdata_d[11:0] = ir_q;
							`BBO_OFF_ACC:     rdata_d[7:0]  = acc_q;
							`BBO_OFF_FLAGS:   rdata_d[2:0]  = flags_q;
							`BBO_OFF_PC:      rdata_d[8:0]  = pc_q;
							`BBO_OFF_CTRL:    rdata_d[`BBO_CTRL_PSA_BIT] = psa_q;
							`BBO_OFF_PIN_DIR: rdata_d[7:0]  = dir_q;
							`BBO_OFF_STAT: begin
								rdata_d[`BBO_STAT_BUSY_BIT] = (core_q != CORE_IDLE);
								rdata_d[`BBO_STAT_SKIP_BIT] = skip_q;
								rdata_d[`BBO_STAT_PCLD_BIT] = pcload_q;
							end
							`BBO_OFF_LATCH:   rdata_d[7:0]  = latch_q;
							`BBO_OFF_ICOUNT:  rdata_d[15:0] = icount_q;
							default:          rdata_d       = 32'h0000_0000;
						endcase
					end
				end
			end
			BUS_ACK: begin
				bus_d = BUS_IDLE;
			end
			default: begin
				bus_d = BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bus_q   <= BUS_IDLE;
			wait_q  <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end else begin
			bus_q   <= bus_d;
			wait_q  <= wait_d;
			rdata_q <= rdata_d;
		end
	end

	// core: four clocks per instruction cycle, decode result applied in phase 1
	always_comb begin
		core_d    = core_q;
		phase_d   = phase_q;
		ir_d      = ir_q;
		acc_d     = acc_q;
		flags_d   = flags_q;
		pc_d      = pc_q;
		psa_d     = psa_q;
		dir_d     = dir_q;
		latch_d   = latch_q;
		skip_d    = skip_q;
		pcload_d  = pcload_q;
		psc_clr_d = 1'b0;
		icount_d  = icount_q;
		mem_we    = 1'b0;
		mem_wa    = fsel;
		mem_wd    = alu.result;
		mem_ra    = (core_q == CORE_IDLE) ? bus_fidx : fsel;
		case (core_q)
			CORE_IDLE: begin
				if (bus_wr && bus_file) begin
					mem_we = 1'b1;
					mem_wa = bus_fidx;
					mem_wd = avs_writedata[7:0];
				end else if (bus_wr) begin
					case (bus_off)
						`BBO_OFF_INSTR: begin
							ir_d     = avs_writedata[11:0];
							core_d   = CORE_EXEC;
							phase_d  = 2'h0;
							skip_d   = 1'b0;
							pcload_d = 1'b0;
						end
						`BBO_OFF_ACC:   acc_d   = avs_writedata[7:0];
						`BBO_OFF_FLAGS: flags_d = bbo_flags_t'(avs_writedata[2:0]);
						`BBO_OFF_PC:    pc_d    = avs_writedata[8:0];
						`BBO_OFF_CTRL:  psa_d   = avs_writedata[`BBO_CTRL_PSA_BIT];
						`BBO_OFF_LATCH: latch_d = avs_writedata[7:0];
						default: begin
							// read-only and unmapped offsets ignore writes
						end
					endcase
				end
			end
			CORE_EXEC: begin
				phase_d = phase_q + 2'h1;
				if (phase_q == `BBO_EXEC_PHASE) begin
					if (alu.wr_acc) begin
						acc_d = alu.result;
					end
					// only the flags the operation owns change
					flags_d = bbo_flags_t'((flags_q & ~alu.upd) | (alu.flags & alu.upd));
					if (alu.skip) begin
						skip_d = 1'b1;
					end
					if (alu.pin_dir) begin
						dir_d = acc_q;
					end
					if (alu.jump) begin
						// the jump carries all nine bits, so bit 8 is not forced
						pc_d     = ir_q[8:0];
						pcload_d = 1'b1;
					end
					if (alu.wr_file) begin
						case (fsel)
							`BBO_FILE_PCL: begin
								pc_d     = {1'b0, alu.result};
								pcload_d = 1'b1;
							end
							`BBO_FILE_IO: begin
								latch_d = alu.result;
							end
							default: begin
								mem_we = 1'b1;
							end
						endcase
						if (fsel == `BBO_FILE_COUNTER && psa_q) begin
							psc_clr_d = 1'b1;
						end
					end
				end
				if (phase_q == LAST_PHASE) begin
					if (!pcload_q) begin
						pc_d = pc_q + 9'h001;
					end
					icount_d = icount_q + 16'h0001;
					core_d   = (skip_q || pcload_q) ? CORE_FLUSH : CORE_IDLE;
					phase_d  = 2'h0;
				end
			end
			CORE_FLUSH: begin
				// the prefetched word is dropped; this cycle is a no-operation
				phase_d = phase_q + 2'h1;
				if (phase_q == LAST_PHASE) begin
					if (skip_q) begin
						pc_d = pc_q + 9'h001;
					end
					core_d  = CORE_IDLE;
					phase_d = 2'h0;
				end
			end
			default: begin
				core_d  = CORE_IDLE;
				phase_d = 2'h0;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			core_q    <= CORE_IDLE;
			phase_q   <= 2'h0;
			ir_q      <= `BBO_RST_IR;
			acc_q     <= `BBO_RST_ACC;
			flags_q   <= bbo_flags_t'(`BBO_RST_FLAGS);
			pc_q      <= `BBO_RST_PC;
			psa_q     <= `BBO_RST_CTRL;
			dir_q     <= `BBO_RST_DIR;
			latch_q   <= `BBO_RST_LATCH;
			skip_q    <= 1'b0;
			pcload_q  <= 1'b0;
			psc_clr_q <= 1'b0;
			icount_q  <= 16'h0000;
		end else begin
			core_q    <= core_d;
			phase_q   <= phase_d;
			ir_q      <= ir_d;
			acc_q     <= acc_d;
			flags_q   <= flags_d;
			pc_q      <= pc_d;
			psa_q     <= psa_d;
			dir_q     <= dir_d;
			latch_q   <= latch_d;
			skip_q    <= skip_d;
			pcload_q  <= pcload_d;
			psc_clr_q <= psc_clr_d;
			icount_q  <= icount_d;
		end
	end

	assign avs_readdata    = rdata_q;
	assign avs_waitrequest = wait_q;
	assign pin_out         = latch_q;
	assign pin_oe_n        = dir_q;
	assign prescaler_clear = psc_clr_q;
endmodule // bbo_exec

// >>> test/bbo_exec_props.sv
// checker for bbo_exec, bound to its top ports
// assumes the register offsets of bbo_params.svh
`timescale 1ns/1ps
`include "bbo_params.svh"
module bbo_exec_props (
	// clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// register bus
	input wire logic [7:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	// pins
	input wire logic [7:0]  pin_in,
	input wire logic [7:0]  pin_out,
	input wire logic [7:0]  pin_oe_n,
	input wire logic        prescaler_clear
);
	logic [3:0] age_q;
	logic [3:0] age_d;
	logic       issue;
	// edges since an issue; saturates so an old issue never aliases a new one
	assign issue = avs_write && !avs_waitrequest && avs_address == `BBO_OFF_INSTR;
	always_comb begin
		age_d = age_q;
		if (issue)
			age_d = 4'h0;
		else if (age_q != 4'hf)
			age_d = age_q + 4'h1;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			age_q <= 4'hf;
		else
			age_q <= age_d;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	wait_pulse_a: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
		else $error("waitrequest low too long");
	wait_bound_a: assert property ((avs_read || avs_write) |-> ##[0:16] !avs_waitrequest)
		else $error("request not answered");
	wait_idle_a: assert property (!(avs_read || avs_write) [*2] |=> avs_waitrequest)
		else $error("answer without request");
	hole_read_a: assert property (avs_read && !avs_waitrequest
		&& avs_address inside {[8'h24:8'h7c]} |-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	dir_read_a: assert property (
		avs_read && !avs_waitrequest && avs_address == `BBO_OFF_PIN_DIR
		|-> avs_readdata == {24'h0, pin_oe_n}) else $error("direction readback differs");
	latch_read_a: assert property (
		avs_read && !avs_waitrequest && avs_address == `BBO_OFF_LATCH
		|-> avs_readdata == {24'h0, pin_out}) else $error("latch readback differs");
	dir_change_a: assert property ($changed(pin_oe_n) |-> age_q == 4'h1)
		else $error("direction changed outside an instruction");
	clear_pulse_a: assert property (
		prescaler_clear |-> age_q == 4'h1 ##1 !prescaler_clear)
		else $error("prescaler clear mistimed");
	out_change_a: assert property ($changed(pin_out) |-> age_q == 4'h1
		|| (avs_write && !avs_waitrequest && avs_address == `BBO_OFF_LATCH))
		else $error("latch changed without cause");
	cover property (issue);
	cover property (prescaler_clear);
	cover property ($changed(pin_oe_n));
endmodule // bbo_exec_props

bind bbo_exec bbo_exec_props u_props (
	.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .pin_out(pin_out),
	.pin_oe_n(pin_oe_n), .prescaler_clear(prescaler_clear)
);

// >>> test/bbo_exec_tb_top.sv
// self-checking bench for the byte and bit execute unit
// assumes bbo_exec and its bound checker are compiled first
`timescale 1ns/1ps
`include "bbo_params.svh"
module bbo_exec_tb_top;
	logic        clk;
	logic        rst;
	logic [7:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [7:0]  pin_in;
	logic [7:0]  pin_out;
	logic [7:0]  pin_oe_n;
	logic        prescaler_clear;
	logic [31:0] rv;
	int          bad_count = 0;
	int          checked = 0;
	int          pulses = 0;
	int          nc;

	bbo_exec DUT (
		.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe_n(pin_oe_n), .prescaler_clear(prescaler_clear)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk)
		if (prescaler_clear === 1'b1)
			pulses++;

	task automatic complete_run();
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", s, e, g);
			bad_count++;
		end
	endtask

	// one access; an idle edge first keeps release and next request apart
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		nc = 0;
		do begin
			@(posedge clk);
			nc++;
		end while (avs_waitrequest !== 1'b0 && nc < 64);
		rv = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			$display("mismatch waitrequest expected 0 seen %b", avs_waitrequest);
			bad_count++;
			complete_run();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a);
		bus(1'b0, a, 32'h0);
	endtask

	task automatic rc(input logic [7:0] a, input string s, input logic [31:0] e);
		rd(a);
		chk(s, e, rv);
	endtask

	task automatic exec(input logic [11:0] i);
		wr(`BBO_OFF_INSTR, {20'h0, i});
	endtask

	task automatic s_reset();
		rc(`BBO_OFF_PIN_DIR, "dir_reset", 32'hff);
		rc(8'h40, "hole", 32'h0);
		wr(`BBO_OFF_PIN_DIR, 32'h0);
		rc(`BBO_OFF_PIN_DIR, "dir_ro", 32'hff);
	endtask

	task automatic s_sum(input logic [7:0] a, input logic [7:0] f, input logic d);
		logic [8:0] s;
		logic [4:0] h;
		s = {1'b0, a} + {1'b0, f};
		h = {1'b0, a[3:0]} + {1'b0, f[3:0]};
		wr(`BBO_OFF_ACC, {24'h0, a});
		wr(8'h94, {24'h0, f});
		wr(`BBO_OFF_FLAGS, 32'h0);
		exec({6'h07, d, 5'h05});
		rc(`BBO_OFF_ACC, "sum_acc", {24'h0, d ? a : s[7:0]});
		rc(8'h94, "sum_file", {24'h0, d ? s[7:0] : f});
		rc(`BBO_OFF_FLAGS, "sum_flags", {29'h0, s[8], h[4], s[7:0] == 8'h0});
	endtask

	task automatic s_and();
		wr(`BBO_OFF_ACC, 32'h0f);
		wr(8'h94, 32'hf0);
		wr(`BBO_OFF_FLAGS, 32'h6);
		exec({6'h05, 1'b0, 5'h05});
		rc(`BBO_OFF_ACC, "and_acc", 32'h0);
		rc(`BBO_OFF_FLAGS, "and_flags", 32'h7);
		wr(`BBO_OFF_ACC, 32'h3c);
		exec(12'hea5);
		rc(`BBO_OFF_ACC, "imm_acc", 32'h24);
		rc(`BBO_OFF_FLAGS, "imm_flags", 32'h6);
		wr(`BBO_OFF_ACC, 32'h55);
		exec(12'h040);
		rc(`BBO_OFF_ACC, "zero_acc", 32'h0);
		rc(`BBO_OFF_FLAGS, "zero_flags", 32'h7);
	endtask

	task automatic s_bits();
		logic [7:0] e;
		e = 8'h00;
		wr(8'h94, 32'h0);
		for (int b = 0; b < 16; b++) begin
			e[b % 8] = b < 8;
			exec({3'b010, b < 8, 3'(b % 8), 5'h05});
			rc(8'h94, "bit_file", {24'h0, e});
		end
		rc(`BBO_OFF_FLAGS, "bit_flags", 32'h7);
	endtask

	task automatic s_skip();
		logic [8:0] p;
		logic       hi;
		logic       sk;
		int         t[2];
		wr(8'h94, 32'h1);
		for (int k = 0; k < 4; k++) begin
			hi = k[0];
			// bit 0 of the operand is high, bit 1 low
			sk = hi == (k < 2);
			rd(`BBO_OFF_PC);
			p = rv[8:0];
			exec({3'b011, hi, 2'b00, k[1], 5'h05});
			rd(`BBO_OFF_STAT);
			t[sk] = nc;
			chk("skip", {31'h0, sk}, {31'h0, rv[1]});
			rc(`BBO_OFF_PC, "skip_pc", {23'h0, p + 9'h1 + {8'h0, sk}});
		end
		chk("skip_time", 32'h4, t[1] - t[0]);
	endtask

	task automatic s_pins();
		wr(`BBO_OFF_ACC, 32'h5a);
		exec(12'h005);
		rc(`BBO_OFF_PIN_DIR, "dir_other", 32'hff);
		exec(12'h006);
		rc(`BBO_OFF_PIN_DIR, "dir_reg", 32'h5a);
		chk("dir_pins", 32'h5a, {24'h0, pin_oe_n});
		pin_in <= 8'h0f;
		wr(`BBO_OFF_LATCH, 32'hff);
		exec({4'h4, 3'h7, 5'h06});
		rc(`BBO_OFF_LATCH, "rmw_latch", 32'h0f);
		chk("rmw_pins", 32'h0f, {24'h0, pin_out});
	endtask

	task automatic s_pc();
		int p;
		wr(`BBO_OFF_PC, 32'h150);
		wr(`BBO_OFF_ACC, 32'h01);
		exec({6'h07, 1'b1, 5'h02});
		rd(`BBO_OFF_PC);
		chk("pc_bit8", 32'h0, {31'h0, rv[8]});
		exec(12'hb23);
		rc(`BBO_OFF_PC, "jump_pc", 32'h123);
		p = pulses;
		wr(`BBO_OFF_CTRL, 32'h1);
		exec({4'h5, 3'h0, 5'h01});
		exec({6'h07, 1'b0, 5'h01});
		wr(`BBO_OFF_CTRL, 32'h0);
		exec({4'h5, 3'h0, 5'h01});
		rd(`BBO_OFF_STAT);
		chk("clear_pulses", 32'h1, pulses - p);
	endtask

	initial begin
		rst = 1'b1;
		avs_address = 8'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		pin_in = 8'ha5;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		s_reset();
		s_sum(8'h88, 8'h88, 1'b0);
		s_sum(8'h10, 8'h88, 1'b1);
		s_sum(8'h80, 8'h80, 1'b0);
		s_sum(8'h0f, 8'h01, 1'b1);
		s_and();
		s_bits();
		s_skip();
		s_pins();
		s_pc();
		complete_run();
	end
endmodule // bbo_exec_tb_top
